// ### hrb_defs.vh
// Purpose: Constants of the host register bank and interrupt logic.
// Assumes: Included by the design files by bare name.
// Notes: Offsets are 5-bit register addresses.
`ifndef HRB_DEFS_VH
`define HRB_DEFS_VH
`define HRB_ADDR_SIGNATURE 5'h00
`define HRB_ADDR_ALOOP 5'h01
`define HRB_ADDR_RLOOP 5'h02
`define HRB_ADDR_ONES 5'h03
`define HRB_ADDR_SA_STAT 5'h04
`define HRB_ADDR_DRV_STAT 5'h05
`define HRB_ADDR_SA_MASK 5'h06
`define HRB_ADDR_DRV_MASK 5'h07
`define HRB_ADDR_SA_FLAG 5'h08
`define HRB_ADDR_DRV_FLAG 5'h09
`define HRB_ADDR_SRST 5'h0A
`define HRB_ADDR_MON 5'h0B
`define HRB_ADDR_DLOOP 5'h0C
`define HRB_ADDR_CRIT 5'h0D
`define HRB_ADDR_AAO 5'h0E
`define HRB_ADDR_GCFG 5'h0F
`define HRB_ADDR_OE 5'h12
`define HRB_ADDR_AI_STAT 5'h13
`define HRB_ADDR_AI_MASK 5'h14
`define HRB_ADDR_AI_FLAG 5'h15
`define HRB_ADDR_BANK 5'h1F
`define HRB_ADDR_EXP_RSV_LO 5'h08
`define HRB_BANK_EXPANDED 8'hAA
`define HRB_RESET_BYTE 8'h00
// The signature value is arbitrary and names no real part.
`define HRB_SIGNATURE_VALUE 8'h5A
`define HRB_CH_BITS 4
`define HRB_CLK_MHZ 50
`define HRB_SRST_NS 1000
`define HRB_SRST_CYCLES ((`HRB_SRST_NS * `HRB_CLK_MHZ) / 1000)
`define HRB_SER_BITS 16
`endif

// ### hrb_serial_port.v
// Purpose: Serial host port: 16-bit frame, command byte then data byte.
// Assumes: Pins are already synchronised; frame is MSB first, sampled on
//   the rising serial clock, framed by an active-low select.
// Notes: Command bit 0 is read/write, bits 5..1 the address.
`include "hrb_defs.vh"
module hrb_serial_port (
  input wire clk,
  input wire resetn,
  input wire ce,
  input wire sel_n,
  input wire sclk,
  input wire serial_in_pin,
  input wire [7:0] rd_data,
  output reg serial_out_pin,
  output reg rd_req,
  output reg wr_req,
  output reg [4:0] addr,
  output reg [7:0] wr_data
);
  reg sclk_d;
  reg [4:0] bitcnt;
  reg [7:0] cmd;
  reg [7:0] shift;
  reg [7:0] rd_shift;
  wire rise = sclk & ~sclk_d;
  wire fall = ~sclk & sclk_d;

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sclk_d <= 1'b0;
      bitcnt <= 5'h00;
      cmd <= 8'h00;
      shift <= 8'h00;
      rd_shift <= 8'h00;
      serial_out_pin <= 1'b0;
      rd_req <= 1'b0;
      wr_req <= 1'b0;
      addr <= 5'h00;
      wr_data <= 8'h00;
    end
    else if (ce)
    begin
      sclk_d <= sclk;
      rd_req <= 1'b0;
      wr_req <= 1'b0;
      if (sel_n)
        bitcnt <= 5'h00;
      else if (rise && bitcnt < `HRB_SER_BITS)
      begin
        bitcnt <= bitcnt + 5'h01;
        shift <= {shift[6:0], serial_in_pin};
        // A one in the read/write bit reads, a zero writes (see RQ18).
        if (bitcnt == 5'h07)
        begin
          cmd <= {shift[6:0], serial_in_pin};
          addr <= shift[4:0];
          if (serial_in_pin)
            rd_req <= 1'b1;
        end
        if (bitcnt == 5'h0F && !cmd[0])
        begin
          wr_data <= {shift[6:0], serial_in_pin};
          wr_req <= 1'b1;
        end
      end
      else if (fall && bitcnt >= 5'h08 && cmd[0])
      begin
        serial_out_pin <= rd_shift[7];
        rd_shift <= {rd_shift[6:0], 1'b0};
      end
      if (rd_req)
        rd_shift <= rd_data;
    end
  end
endmodule

// ### hrb_parallel_port.v
// Purpose: Parallel host port: strobe-based read and write of 5-bit address.
// Assumes: Pins synchronised; multiplexed mode latches address on ale.
// Notes: One request pulse per strobe: reads on strobe assertion, writes on strobe release.
module hrb_parallel_port (
  input wire clk,
  input wire resetn,
  input wire ce,
  input wire mux_mode,
  input wire cs_n,
  input wire rd_n,
  input wire wr_n,
  input wire ale,
  input wire [4:0] addr_pins,
  input wire [7:0] data_in,
  output reg rd_req,
  output reg wr_req,
  output reg [4:0] addr,
  output reg [7:0] wr_data
);
  reg rd_d;
  reg wr_d;
  reg [4:0] latched;
  wire rd_act = ~cs_n & ~rd_n;
  wire wr_act = ~cs_n & ~wr_n;
  // Five address bits: dedicated lines, or the low multiplexed lines
  // (see RQ13).
  wire [4:0] cur_addr = mux_mode ? latched : addr_pins;

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rd_d <= 1'b0;
      wr_d <= 1'b0;
      latched <= 5'h00;
      rd_req <= 1'b0;
      wr_req <= 1'b0;
      addr <= 5'h00;
      wr_data <= 8'h00;
    end
    else if (ce)
    begin
      rd_d <= rd_act;
      wr_d <= wr_act;
      if (ale)
        latched <= data_in[4:0];
      rd_req <= rd_act & ~rd_d;
      // Writes take effect when the strobe is released, data is stable then.
      wr_req <= wr_d & ~wr_act;
      if ((rd_act & ~rd_d) | wr_act)
        addr <= cur_addr;
      if (wr_act)
        wr_data <= data_in;
    end
  end
endmodule

// ### hrb_register_bank.v
// Purpose: Host register bank with bank pointer and latched interrupt.
// Assumes: One 50 MHz clock; host pins and status inputs are asynchronous
//   and pass two flip-flops here before use.
// Notes: Expanded bank is a plain byte store; line datapath lives outside.
//
// Behaviour
// RQ1 - Interrupts come only from signal absence, driver fault, alarm changes.
// RQ2 - Signal absence status follows its detector on each channel.
// RQ3 - Driver fault status follows short-circuit monitor on each channel.
// RQ4 - Alarm indication status follows its detector on each channel.
// RQ5 - One latched active-low open-drain interrupt output reports all sources.
// RQ6 - Mask bit one enables that channel's flag for that source.
// RQ7 - Any change of an enabled status bit sets its flag, asserts interrupt.
// RQ8 - Masks reset to zero; a zero mask ignores status changes.
// RQ9 - Host reads the three flag registers to find the cause.
// RQ10 - Reading a status register clears its matching flag register.
// RQ11 - Status bits are live, not latched, and clear with the condition.
// RQ12 - Interrupt released only when no flag remains pending.
// RQ13 - Five address bits select registers on every host port.
// RQ14 - Bank pointer 0xAA selects expanded bank; cleared selects primary.
// RQ15 - Primary 10,11,16-1E and expanded 08-0F are reserved.
// RQ16 - Host keeps expanded test registers 10-1E at zero.
// RQ17 - Host writes reserved bit positions with their default value.
// RQ18 - Serial frame: command byte with read/write and address, then data.
// RQ19 - Writing the soft reset register resets all registers for about 1 us.
// RQ20 - Bit n of per-channel registers is channel n; upper nibble reserved.
`include "hrb_defs.vh"
module hrb_register_bank (
  input wire clk,
  input wire resetn,
  input wire ce,
  input wire serial_mode,
  input wire mux_mode,
  input wire cs_n,
  input wire rd_n,
  input wire wr_n,
  input wire ale,
  input wire [4:0] addr_pins,
  input wire [7:0] data_in,
  output reg [7:0] data_out,
  output wire data_oe,
  input wire sclk,
  input wire serial_in_pin,
  output wire serial_out_pin,
  input wire [3:0] signal_absence,
  input wire [3:0] driver_fault,
  input wire [3:0] alarm_indication,
  output wire irq_n_out,
  output wire irq_n_oe,
  output reg [7:0] analog_loopback_ctrl,
  output reg [7:0] remote_loopback_ctrl,
  output reg [7:0] all_ones_tx_ctrl,
  output reg [7:0] monitor_select,
  output reg [7:0] digital_loopback_ctrl,
  output reg [7:0] signal_criteria_cfg,
  output reg [7:0] auto_all_ones_ctrl,
  output reg [7:0] global_cfg,
  output reg [7:0] output_enable_cfg,
  output wire soft_reset_active
);
  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  reg [24:0] sync1;
  reg [24:0] sync2;
  wire [24:0] raw_in = {serial_mode, mux_mode, cs_n, rd_n, wr_n, ale,
    sclk, serial_in_pin, addr_pins, signal_absence, driver_fault,
    alarm_indication};

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sync1 <= 25'h0700000;
      sync2 <= 25'h0700000;
    end
    else if (ce)
    begin
      sync1 <= raw_in;
      sync2 <= sync1;
    end
  end

  wire s_serial = sync2[24];
  wire s_mux = sync2[23];
  wire s_cs_n = sync2[22];
  wire s_rd_n = sync2[21];
  wire s_wr_n = sync2[20];
  wire s_ale = sync2[19];
  wire s_sclk = sync2[18];
  wire s_ser_in = sync2[17];
  wire [4:0] s_addr = sync2[16:12];
  wire [3:0] s_sa = sync2[11:8];
  wire [3:0] s_drv = sync2[7:4];
  wire [3:0] s_ai = sync2[3:0];

  // Data bus lines are sampled while a write strobe is low for several
  // cycles, so they are read only through a second stage as well.
  reg [7:0] din1;
  reg [7:0] din2;
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      din1 <= 8'h00;
      din2 <= 8'h00;
    end
    else if (ce)
    begin
      din1 <= data_in;
      din2 <= din1;
    end
  end

  // ----------------------------------------------------------------------
  // Host ports
  // ----------------------------------------------------------------------
  wire p_rd;
  wire p_wr;
  wire [4:0] p_addr;
  wire [7:0] p_data;
  wire s_rd;
  wire s_wr;
  wire [4:0] sr_addr;
  wire [7:0] sr_data;
  wire [7:0] read_value;

  hrb_parallel_port u_par (
    .clk(clk),
    .resetn(resetn),
    .ce(ce & ~s_serial),
    .mux_mode(s_mux),
    .cs_n(s_cs_n),
    .rd_n(s_rd_n),
    .wr_n(s_wr_n),
    .ale(s_ale),
    .addr_pins(s_addr),
    .data_in(din2),
    .rd_req(p_rd),
    .wr_req(p_wr),
    .addr(p_addr),
    .wr_data(p_data)
  );

  hrb_serial_port u_ser (
    .clk(clk),
    .resetn(resetn),
    .ce(ce & s_serial),
    .sel_n(s_cs_n),
    .sclk(s_sclk),
    .serial_in_pin(s_ser_in),
    .rd_data(read_value),
    .serial_out_pin(serial_out_pin),
    .rd_req(s_rd),
    .wr_req(s_wr),
    .addr(sr_addr),
    .wr_data(sr_data)
  );

  // Serial addresses come from command bits 5..1 (see RQ13).
  wire [4:0] acc_addr = s_serial ? sr_addr : p_addr;
  wire acc_rd = s_serial ? s_rd : p_rd;
  wire acc_wr = s_serial ? s_wr : p_wr;
  wire [7:0] acc_data = s_serial ? sr_data : p_data;

  // ----------------------------------------------------------------------
  // Soft reset
  // ----------------------------------------------------------------------
  localparam [31:0] SRST_FULL = `HRB_SRST_CYCLES;
  localparam [5:0] SRST_LEN = SRST_FULL[5:0];
  reg [5:0] srst_cnt;
  reg [7:0] bank_pointer;
  wire expanded = (bank_pointer == `HRB_BANK_EXPANDED);
  wire srst_hit = acc_wr & ~expanded & (acc_addr == `HRB_ADDR_SRST);
  assign soft_reset_active = (srst_cnt != 6'h00);

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      srst_cnt <= 6'h00;
    else if (ce)
    begin
      if (srst_hit)
        srst_cnt <= SRST_LEN; // see RQ19
      else if (srst_cnt != 6'h00)
        srst_cnt <= srst_cnt - 6'h01;
    end
  end

  // ----------------------------------------------------------------------
  // Status, masks and flags
  // ----------------------------------------------------------------------
  reg [3:0] sa_prev;
  reg [3:0] drv_prev;
  reg [3:0] ai_prev;
  reg [3:0] sa_mask;
  reg [3:0] drv_mask;
  reg [3:0] ai_mask;
  reg [3:0] sa_flag;
  reg [3:0] drv_flag;
  reg [3:0] ai_flag;
  reg [7:0] exp_store [0:7];

  // Flag update: set wins over clear-on-read so no change is lost.
  function [3:0] flag_next;
    input [3:0] flag;
    input [3:0] now;
    input [3:0] prev;
    input [3:0] mask;
    input clr;
    begin
      flag_next = (clr ? 4'h0 : flag) | ((now ^ prev) & mask);
    end
  endfunction

  wire prim_rd = acc_rd & ~expanded;
  wire prim_wr = acc_wr & ~expanded & ~soft_reset_active;
  wire clr_sa = prim_rd & (acc_addr == `HRB_ADDR_SA_STAT); // see RQ10
  wire clr_drv = prim_rd & (acc_addr == `HRB_ADDR_DRV_STAT);
  wire clr_ai = prim_rd & (acc_addr == `HRB_ADDR_AI_STAT);
  integer i;

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sa_prev <= 4'h0;
      drv_prev <= 4'h0;
      ai_prev <= 4'h0;
      sa_mask <= 4'h0;
      drv_mask <= 4'h0;
      ai_mask <= 4'h0;
      sa_flag <= 4'h0;
      drv_flag <= 4'h0;
      ai_flag <= 4'h0;
      bank_pointer <= `HRB_RESET_BYTE;
      analog_loopback_ctrl <= `HRB_RESET_BYTE;
      remote_loopback_ctrl <= `HRB_RESET_BYTE;
      all_ones_tx_ctrl <= `HRB_RESET_BYTE;
      monitor_select <= `HRB_RESET_BYTE;
      digital_loopback_ctrl <= `HRB_RESET_BYTE;
      signal_criteria_cfg <= `HRB_RESET_BYTE;
      auto_all_ones_ctrl <= `HRB_RESET_BYTE;
      global_cfg <= `HRB_RESET_BYTE;
      output_enable_cfg <= `HRB_RESET_BYTE;
      for (i = 0; i < 8; i = i + 1)
        exp_store[i] <= `HRB_RESET_BYTE;
    end
    else if (ce)
    begin
      // Status is live; previous values track it even while masked.
      sa_prev <= s_sa; // see RQ2
      drv_prev <= s_drv; // see RQ3
      ai_prev <= s_ai; // see RQ4
      if (soft_reset_active)
      begin
        sa_mask <= 4'h0;
        drv_mask <= 4'h0;
        ai_mask <= 4'h0;
        sa_flag <= 4'h0;
        drv_flag <= 4'h0;
        ai_flag <= 4'h0;
        bank_pointer <= `HRB_RESET_BYTE;
        analog_loopback_ctrl <= `HRB_RESET_BYTE;
        remote_loopback_ctrl <= `HRB_RESET_BYTE;
        all_ones_tx_ctrl <= `HRB_RESET_BYTE;
        monitor_select <= `HRB_RESET_BYTE;
        digital_loopback_ctrl <= `HRB_RESET_BYTE;
        signal_criteria_cfg <= `HRB_RESET_BYTE;
        auto_all_ones_ctrl <= `HRB_RESET_BYTE;
        global_cfg <= `HRB_RESET_BYTE;
        output_enable_cfg <= `HRB_RESET_BYTE;
        for (i = 0; i < 8; i = i + 1)
          exp_store[i] <= `HRB_RESET_BYTE; // see RQ19
      end
      else
      begin
        // Three sources only, masked per channel (see RQ1, RQ6, RQ7, RQ8).
        sa_flag <= flag_next(sa_flag, s_sa, sa_prev, sa_mask, clr_sa);
        drv_flag <= flag_next(drv_flag, s_drv, drv_prev, drv_mask, clr_drv);
        ai_flag <= flag_next(ai_flag, s_ai, ai_prev, ai_mask, clr_ai);
        if (acc_wr && acc_addr == `HRB_ADDR_BANK)
          bank_pointer <= acc_data; // see RQ14
        if (acc_wr && expanded && acc_addr < `HRB_ADDR_EXP_RSV_LO)
          exp_store[acc_addr[2:0]] <= acc_data;
        if (prim_wr)
        begin
          // Only the low nibble exists per channel (see RQ20).
          case (acc_addr)
            `HRB_ADDR_ALOOP: analog_loopback_ctrl <= {4'h0, acc_data[3:0]};
            `HRB_ADDR_RLOOP: remote_loopback_ctrl <= {4'h0, acc_data[3:0]};
            `HRB_ADDR_ONES: all_ones_tx_ctrl <= {4'h0, acc_data[3:0]};
            `HRB_ADDR_SA_MASK: sa_mask <= acc_data[3:0];
            `HRB_ADDR_DRV_MASK: drv_mask <= acc_data[3:0];
            `HRB_ADDR_AI_MASK: ai_mask <= acc_data[3:0];
            `HRB_ADDR_MON: monitor_select <= acc_data;
            `HRB_ADDR_DLOOP: digital_loopback_ctrl <= {4'h0, acc_data[3:0]};
            `HRB_ADDR_CRIT: signal_criteria_cfg <= acc_data;
            `HRB_ADDR_AAO: auto_all_ones_ctrl <= {4'h0, acc_data[3:0]};
            `HRB_ADDR_GCFG: global_cfg <= acc_data;
            `HRB_ADDR_OE: output_enable_cfg <= {4'h0, acc_data[3:0]};
            default: ;
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------------------
  // Reserved addresses and test registers read as zero; test registers
  // are not stored since they must stay zero (see RQ15, RQ16).
  reg [7:0] rv;
  always @*
  begin
    rv = 8'h00;
    if (acc_addr == `HRB_ADDR_BANK)
      rv = bank_pointer;
    else if (expanded)
    begin
      if (acc_addr < `HRB_ADDR_EXP_RSV_LO)
        rv = exp_store[acc_addr[2:0]];
    end
    else
    begin
      case (acc_addr)
        `HRB_ADDR_SIGNATURE: rv = `HRB_SIGNATURE_VALUE;
        `HRB_ADDR_ALOOP: rv = analog_loopback_ctrl;
        `HRB_ADDR_RLOOP: rv = remote_loopback_ctrl;
        `HRB_ADDR_ONES: rv = all_ones_tx_ctrl;
        `HRB_ADDR_SA_STAT: rv = {4'h0, s_sa}; // see RQ11
        `HRB_ADDR_DRV_STAT: rv = {4'h0, s_drv};
        `HRB_ADDR_AI_STAT: rv = {4'h0, s_ai};
        `HRB_ADDR_SA_MASK: rv = {4'h0, sa_mask};
        `HRB_ADDR_DRV_MASK: rv = {4'h0, drv_mask};
        `HRB_ADDR_AI_MASK: rv = {4'h0, ai_mask};
        `HRB_ADDR_SA_FLAG: rv = {4'h0, sa_flag}; // see RQ9
        `HRB_ADDR_DRV_FLAG: rv = {4'h0, drv_flag};
        `HRB_ADDR_AI_FLAG: rv = {4'h0, ai_flag};
        `HRB_ADDR_MON: rv = monitor_select;
        `HRB_ADDR_DLOOP: rv = digital_loopback_ctrl;
        `HRB_ADDR_CRIT: rv = signal_criteria_cfg;
        `HRB_ADDR_AAO: rv = auto_all_ones_ctrl;
        `HRB_ADDR_GCFG: rv = global_cfg;
        `HRB_ADDR_OE: rv = output_enable_cfg;
        default: rv = 8'h00;
      endcase
    end
  end
  assign read_value = rv;

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      data_out <= 8'h00;
    else if (ce && acc_rd)
      data_out <= rv;
  end

  assign data_oe = ~s_serial & ~s_cs_n & ~s_rd_n;

  // ----------------------------------------------------------------------
  // Interrupt pin
  // ----------------------------------------------------------------------
  // Open drain: the pin only ever pulls low, held while any flag is
  // pending (see RQ5, RQ12).
  assign irq_n_out = 1'b0;
  assign irq_n_oe = |{sa_flag, drv_flag, ai_flag};
endmodule

// ### hrb_register_bank_assertions.sv
// Purpose: Port-level checks of the host register bank and its interrupt.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes: Windows of a few cycles cover the input synchronisers.
module hrb_register_bank_chk (
  input wire clk,
  input wire resetn,
  input wire cs_n,
  input wire [3:0] signal_absence,
  input wire [3:0] driver_fault,
  input wire [3:0] alarm_indication,
  input wire irq_n_out,
  input wire irq_n_oe,
  input wire [7:0] analog_loopback_ctrl,
  input wire [7:0] global_cfg,
  input wire [7:0] output_enable_cfg,
  input wire soft_reset_active
);
  localparam int srst_cyc = 50;
  logic [3:0] chg_age;
  logic [3:0] cs_age;
  logic [7:0] sr_cnt;
  wire [23:0] cfg_all = {analog_loopback_ctrl, global_cfg, output_enable_cfg};
  // ----------------------------------------
  // Helper counters
  // ----------------------------------------
  // Ages saturate so that a long quiet spell never wraps to a small count.
  always @(posedge clk or negedge resetn)
    if (!resetn)
      chg_age <= 4'hF;
    else
      chg_age <= $changed({signal_absence, driver_fault, alarm_indication})
        ? 4'h0 : chg_age + {3'h0, chg_age != 4'hF};
  always @(posedge clk or negedge resetn)
    if (!resetn)
      cs_age <= 4'hF;
    else
      cs_age <= !cs_n ? 4'h0 : cs_age + {3'h0, cs_age != 4'hF};
  always @(posedge clk or negedge resetn)
    if (!resetn)
      sr_cnt <= 8'h00;
    else
      sr_cnt <= soft_reset_active ? sr_cnt + 8'h01 : 8'h00;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  a_irq_pin_low:
    assert property (irq_n_out == 1'b0)
    else $error("interrupt pin not low");
  a_irq_quiet_boot:
    assert property ($rose(resetn) |-> !irq_n_oe [*8])
    else $error("interrupt raised straight after reset");
  a_irq_has_cause:
    assert property ($rose(irq_n_oe) |-> chg_age <= 4'h5)
    else $error("interrupt raised without a status change");
  a_irq_drop_read:
    assert property ($fell(irq_n_oe) |-> cs_age <= 4'h8)
    else $error("interrupt released without a host access");
  a_cfg_needs_host:
    assert property (!$stable(cfg_all) |-> cs_age <= 4'h8)
    else $error("config changed without host access");
  a_lane_nibble_only:
    assert property ({analog_loopback_ctrl[7:4], output_enable_cfg[7:4]}
      == 8'h00)
    else $error("per-channel upper nibble set");
  a_srst_length:
    assert property ($fell(soft_reset_active) |-> sr_cnt == srst_cyc)
    else $error("soft reset length is wrong");
  a_srst_clears:
    assert property (soft_reset_active && $past(soft_reset_active)
      |-> cfg_all == 24'h000000 && !irq_n_oe)
    else $error("state kept during soft reset");
  c_irq_raised: cover property ($rose(irq_n_oe));
  c_irq_released: cover property ($fell(irq_n_oe));
  c_srst_done: cover property ($fell(soft_reset_active));
endmodule
bind hrb_register_bank hrb_register_bank_chk chk (
  .clk(clk), .resetn(resetn), .cs_n(cs_n),
  .signal_absence(signal_absence), .driver_fault(driver_fault),
  .alarm_indication(alarm_indication), .irq_n_out(irq_n_out),
  .irq_n_oe(irq_n_oe), .analog_loopback_ctrl(analog_loopback_ctrl),
  .global_cfg(global_cfg), .output_enable_cfg(output_enable_cfg),
  .soft_reset_active(soft_reset_active)
);

// ### hrb_host_model.sv
// Purpose: Host processor model for the parallel and serial ports.
// Assumes: Pins change just after the falling clock edge.
// Notes: Released data lines show the inverse of their last value.
module hrb_host_model (
  input wire clk,
  input wire [7:0] data_out,
  input wire data_oe,
  input wire serial_out_pin,
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic ale,
  output logic [4:0] addr_pins,
  output logic [7:0] data_in,
  output logic sclk,
  output logic serial_in_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Bus cycles
  // ----------------------------------------
  initial
  begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    ale = 1'b0;
    addr_pins = 5'h00;
    data_in = 8'h00;
    sclk = 1'b0;
    serial_in_pin = 1'b0;
  end
  // Test registers are never written, so they stay zero.
  task automatic par_wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge clk);
    cs_n = 1'b0;
    addr_pins = a;
    data_in = d;
    wr_n = 1'b0;
    repeat (6) @(negedge clk);
    wr_n = 1'b1;
    cs_n = 1'b1;
    repeat (6) @(negedge clk);
    data_in = ~d;
  endtask
  task automatic par_rd(input logic [4:0] a, output logic [7:0] q);
    @(negedge clk);
    cs_n = 1'b0;
    addr_pins = a;
    rd_n = 1'b0;
    repeat (6) @(negedge clk);
    q = data_oe ? data_out : ~data_out;
    rd_n = 1'b1;
    cs_n = 1'b1;
    repeat (6) @(negedge clk);
  endtask
  // Halves of six cycles leave room for the port's sclk synchroniser.
  task automatic ser_xfer(input logic rw, input logic [4:0] a,
    input logic [7:0] d, output logic [7:0] q);
    logic [15:0] f;
    f = {2'b00, a, rw, d};
    @(negedge clk);
    cs_n = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      serial_in_pin = f[i];
      repeat (6) @(negedge clk);
      if (i < 8)
        q[i] = serial_out_pin;
      sclk = 1'b1;
      repeat (6) @(negedge clk);
      sclk = 1'b0;
    end
    repeat (6) @(negedge clk);
    cs_n = 1'b1;
    serial_in_pin = ~serial_in_pin;
    repeat (6) @(negedge clk);
  endtask
endmodule

// ### host_register_bank_irq_tb_top.sv
// Purpose: Self-checking bench of the host register bank and interrupt.
// Assumes: Host model drives all bus pins at the falling clock edge.
// Notes: Only separate-bus parallel and serial host modes are exercised.
`include "hrb_defs.vh"
`define CHK(g, e) check_val(g, e)
module host_register_bank_irq_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, resetn, serial_mode, cs_n, rd_n, wr_n, ale, sclk;
  logic serial_in_pin, serial_out_pin, irq_n_out, irq_n_oe;
  logic soft_reset_active, data_oe;
  logic [4:0] addr_pins;
  logic [7:0] data_in, data_out, q, d;
  logic [7:0] wv [32];
  logic [3:0] stat [3];
  logic [3:0] m [3], s [3];
  wire [71:0] cfg;
  wire irq_line = irq_n_oe ? irq_n_out : 1'b1;
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;
  logic [4:0] cfg_addr [9] = '{5'h01, 5'h02, 5'h03, 5'h0B, 5'h0C, 5'h0D,
    5'h0E, 5'h0F, 5'h12};
  logic [4:0] st_addr [3] = '{5'h04, 5'h05, 5'h13};
  logic [4:0] mk_addr [3] = '{5'h06, 5'h07, 5'h14};
  logic [4:0] fl_addr [3] = '{5'h08, 5'h09, 5'h15};
  hrb_register_bank dut (
    .clk(clk), .resetn(resetn), .ce(1'b1), .serial_mode(serial_mode),
    .mux_mode(1'b0), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .ale(ale),
    .addr_pins(addr_pins), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .sclk(sclk), .serial_in_pin(serial_in_pin),
    .serial_out_pin(serial_out_pin), .signal_absence(stat[0]),
    .driver_fault(stat[1]), .alarm_indication(stat[2]),
    .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe),
    .analog_loopback_ctrl(cfg[7:0]), .remote_loopback_ctrl(cfg[15:8]),
    .all_ones_tx_ctrl(cfg[23:16]), .monitor_select(cfg[31:24]),
    .digital_loopback_ctrl(cfg[39:32]), .signal_criteria_cfg(cfg[47:40]),
    .auto_all_ones_ctrl(cfg[55:48]), .global_cfg(cfg[63:56]),
    .output_enable_cfg(cfg[71:64]), .soft_reset_active(soft_reset_active)
  );
  hrb_host_model host (
    .clk(clk), .data_out(data_out), .serial_out_pin(serial_out_pin),
    .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .ale(ale),
    .addr_pins(addr_pins), .data_in(data_in), .sclk(sclk),
    .serial_in_pin(serial_in_pin), .data_oe(data_oe)
  );
  // ----------------------------------------
  // Checking helpers
  // ----------------------------------------
  function automatic logic [7:0] rw_mask(input logic [4:0] a);
    case (a)
      5'h0B, 5'h0D, 5'h0F: return 8'hFF;
      5'h01, 5'h02, 5'h03, 5'h06, 5'h07, 5'h0C, 5'h0E, 5'h12, 5'h14:
        return 8'h0F;
      default: return 8'h00;
    endcase
  endfunction
  function automatic logic [7:0] exp_rd(input logic [4:0] a,
    input logic [7:0] v);
    if (a == 5'h00)
      return `HRB_SIGNATURE_VALUE;
    return v & rw_mask(a);
  endfunction
  task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check_defaults;
    for (int a = 0; a < 32; a++)
      if (a != 10)
      begin
        host.par_rd(5'(a), q);
        `CHK(q, exp_rd(5'(a), 8'h00));
      end
  endtask
  task print_verdict;
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Ceiling: several times the cycles the run needs.
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      miscompares++;
      print_verdict();
    end
  end
  initial
  begin
    resetn = 1'b0;
    serial_mode = 1'b0;
    foreach (stat[k])
      stat[k] = 4'h0;
    void'($urandom(17971));
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    repeat (3) @(negedge clk);
    check_defaults();
    $display("test defaults done");
    for (int a = 0; a < 31; a++)
      if (a != 10)
      begin
        wv[a] = 8'($urandom);
        if (rw_mask(5'(a)) != 8'h00)
          wv[a] = wv[a] & rw_mask(5'(a));
        host.par_wr(5'(a), wv[a]);
        host.par_rd(5'(a), q);
        `CHK(q, exp_rd(5'(a), wv[a]));
      end
    for (int i = 0; i < 9; i++)
      `CHK(cfg[8*i +: 8], wv[cfg_addr[i]]);
    $display("test register access done");
    for (int k = 0; k < 3; k++)
    begin
      host.par_wr(mk_addr[k], 8'h00);
      stat[k] = 4'hF;
      repeat (6) @(negedge clk);
      stat[k] = 4'h0;
      repeat (6) @(negedge clk);
      host.par_rd(fl_addr[k], q);
      `CHK(q, 8'h00);
      m[k] = 4'($urandom) | 4'h1;
      s[k] = 4'($urandom) | 4'h1;
      host.par_wr(mk_addr[k], {4'h0, m[k]});
      stat[k] = s[k];
      repeat (6) @(negedge clk);
      `CHK(irq_line, 1'b0);
    end
    for (int p = 0; p < 2; p++)
    begin
      if (p == 1)
        foreach (stat[k])
          stat[k] = 4'h0;
      repeat (6) @(negedge clk);
      for (int k = 0; k < 3; k++)
      begin
        host.par_rd(fl_addr[k], q);
        `CHK(q, {4'h0, s[k] & m[k]});
        host.par_rd(st_addr[k], q);
        `CHK(q, (p == 1) ? 8'h00 : {4'h0, s[k]});
        host.par_rd(fl_addr[k], q);
        `CHK(q, 8'h00);
        `CHK(irq_line, k == 2);
      end
    end
    $display("test interrupts done");
    host.par_wr(`HRB_ADDR_BANK, `HRB_BANK_EXPANDED);
    d = 8'($urandom);
    host.par_wr(5'h01, d);
    host.par_rd(5'h01, q);
    `CHK(q, d);
    host.par_wr(`HRB_ADDR_EXP_RSV_LO, d);
    host.par_rd(`HRB_ADDR_EXP_RSV_LO, q);
    `CHK(q, 8'h00);
    host.par_rd(`HRB_ADDR_BANK, q);
    `CHK(q, `HRB_BANK_EXPANDED);
    host.par_wr(`HRB_ADDR_BANK, 8'h00);
    host.par_rd(5'h01, q);
    `CHK(q, wv[1]);
    $display("test bank pointer done");
    serial_mode = 1'b1;
    repeat (4) @(negedge clk);
    d = 8'($urandom) | 8'h80;
    host.ser_xfer(1'b0, `HRB_ADDR_GCFG, d, q);
    host.ser_xfer(1'b1, `HRB_ADDR_GCFG, 8'h00, q);
    `CHK(q, d);
    `CHK(cfg[63:56], d);
    host.ser_xfer(1'b1, `HRB_ADDR_SIGNATURE, 8'h00, q);
    `CHK(q, `HRB_SIGNATURE_VALUE);
    serial_mode = 1'b0;
    repeat (4) @(negedge clk);
    $display("test serial port done");
    host.par_wr(`HRB_ADDR_SRST, 8'h00);
    `CHK(soft_reset_active, 1'b1);
    for (int n = 0; n < 100 && soft_reset_active === 1'b1; n++)
      @(negedge clk);
    `CHK(soft_reset_active, 1'b0);
    check_defaults();
    $display("test soft reset done");
    print_verdict();
  end
endmodule
